//--- gppc_top.sv
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
// Function
// - direction bit: 0 input hi-z, 1 drives
// - reset clears direction, pins start input
// - input register read-only, live pin level
// - output data read returns last written
// - output data untouched by reset
// - pull-up only GPIO with buffer off
// - reset clears pull-up enables
// - slew bit: 0 slow, 1 fast, all modes
// - reset clears slew select, slow slew
// - choice 0 first, 1 second; needs enable
// - port F choice routes serial or timer
// - port J wake-up inputs; seconds reserved on pins 0-6
// - open-drain: dout 0, toggle direction
// - eight-bit registers, bit n pin n
// - function choice independent per pin
// - enable 0 GPIO, 1 peripheral drives pin
// - reset clears alternate function enables
// - input buffer on during read or alternate
module gppc_top
  import gppc_pkg::*;
#(
  parameter int unsigned           NPORTS        = 7,
  parameter logic [NPORTS*8-1:0]   ALT1_RESERVED =
    ALT1_RESERVED_DEF[NPORTS*8-1:0]
) (
  // clock, reset, enable
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0]   awaddr,
  input  wire logic [2:0]          awprot,
  input  wire logic                awvalid,
  output logic                     awready,
  // axi4-lite write data
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  // axi4-lite write response
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0]   araddr,
  input  wire logic [2:0]          arprot,
  input  wire logic                arvalid,
  output logic                     arready,
  // axi4-lite read data
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  // package pins
  input  wire logic [NPORTS*8-1:0] pin_in,
  output logic [NPORTS*8-1:0]      pin_out,
  output logic [NPORTS*8-1:0]      pin_oe,
  output logic [NPORTS*8-1:0]      pin_pullup_en,
  output logic [NPORTS*8-1:0]      pin_fast_slew,
  output logic [NPORTS*8-1:0]      pin_in_buf_en,
  // peripheral alternate functions
  input  wire logic [NPORTS*8-1:0] alt0_out,
  input  wire logic [NPORTS*8-1:0] alt0_oe,
  input  wire logic [NPORTS*8-1:0] alt1_out,
  input  wire logic [NPORTS*8-1:0] alt1_oe,
  output logic [NPORTS*8-1:0]      periph_in
);

  localparam int unsigned NP = NPORTS * 8;

  function automatic int unsigned port_of(input logic [ADDR_W-1:0] a);
    return int'(a[PORT_LSB +: PORT_W]);
  endfunction

  function automatic logic [3:0] idx_of(input logic [ADDR_W-1:0] a);
    return a[IDX_LSB +: IDX_W];
  endfunction

  function automatic logic decode_ok(input logic [ADDR_W-1:0] a);
    logic [3:0] i;
    i = idx_of(a);
    return (port_of(a) < NPORTS) && !i[0] && (i <= IDX_FN_CHOICE)
           && (a[ADDR_W-1:PORT_LSB+PORT_W] == '0);
  endfunction

  logic [NP-1:0]     dir_r;
  logic [NP-1:0]     dout_r;
  logic [NP-1:0]     pullup_r;
  logic [NP-1:0]     slew_r;
  logic [NP-1:0]     alt_en_r;
  logic [NP-1:0]     choice_r;
  logic [NP-1:0]     sync1_r;
  logic [NP-1:0]     sync2_r;

  logic              aw_full_r;
  logic              w_full_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0]        w_data_r;
  logic              w_lane0_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              rvalid_r;
  logic [7:0]        rdata_r;
  logic [1:0]        rresp_r;

  logic              aw_hs;
  logic              w_hs;
  logic              wr_go;
  logic              wr_en;
  int unsigned       wr_port;
  logic [3:0]        wr_idx;
  logic              ar_hs;
  logic [7:0]        rd_val;

  // write channel: address and data taken in either order
  assign awready = ce & ~aw_full_r & ~bvalid_r;
  assign wready  = ce & ~w_full_r & ~bvalid_r;
  assign aw_hs   = awvalid & awready;
  assign w_hs    = wvalid & wready;
  assign wr_go   = ce & aw_full_r & w_full_r;
  assign wr_port = port_of(aw_addr_r);
  assign wr_idx  = idx_of(aw_addr_r);
  assign wr_en   = wr_go & decode_ok(aw_addr_r) & w_lane0_r
                   & (wr_idx != IDX_DIN);
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else if (ce) begin
      if (aw_hs) begin
        aw_full_r <= 1'b1;
      end
      if (w_hs) begin
        w_full_r <= 1'b1;
      end
      if (wr_go) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= (decode_ok(aw_addr_r) && wr_idx != IDX_DIN)
                     ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (ce && aw_hs) begin
      aw_addr_r <= awaddr;
    end
    if (ce && w_hs) begin
      w_data_r  <= wdata[7:0];
      w_lane0_r <= wstrb[0];
    end
  end

  // control registers, each byte one port, bit n pin n
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dir_r    <= {NPORTS{RST_DIR}};
      pullup_r <= {NPORTS{RST_PULLUP}};
      slew_r   <= {NPORTS{RST_SLEW}};
      alt_en_r <= {NPORTS{RST_ALT_EN}};
      choice_r <= {NPORTS{RST_FN_CHOICE}};
    end else if (wr_en) begin
      unique case (wr_idx)
        IDX_DIR:       dir_r[wr_port*8 +: 8]    <= w_data_r;
        IDX_PULLUP:    pullup_r[wr_port*8 +: 8] <= w_data_r;
        IDX_SLEW:      slew_r[wr_port*8 +: 8]   <= w_data_r;
        IDX_ALT_EN:    alt_en_r[wr_port*8 +: 8] <= w_data_r;
        IDX_FN_CHOICE: choice_r[wr_port*8 +: 8] <= w_data_r;
        default: ;
      endcase
    end
  end

  // output data keeps its value through reset
  always_ff @(posedge aclk) begin
    if (wr_en && wr_idx == IDX_DOUT) begin
      dout_r[wr_port*8 +: 8] <= w_data_r;
    end
  end

  // pin level synchronizer
  always_ff @(posedge aclk) begin
    if (ce) begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // read channel
  assign arready = ce & ~rvalid_r;
  assign ar_hs   = arvalid & arready;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = {24'h000000, rdata_r};

  always_comb begin
    int unsigned p;
    p      = port_of(araddr);
    rd_val = 8'h00;
    if (decode_ok(araddr)) begin
      unique case (idx_of(araddr))
        IDX_DIR:       rd_val = dir_r[p*8 +: 8];
        IDX_DIN:       rd_val = sync2_r[p*8 +: 8];
        IDX_DOUT:      rd_val = dout_r[p*8 +: 8];
        IDX_PULLUP:    rd_val = pullup_r[p*8 +: 8];
        IDX_SLEW:      rd_val = slew_r[p*8 +: 8];
        IDX_ALT_EN:    rd_val = alt_en_r[p*8 +: 8];
        IDX_FN_CHOICE: rd_val = choice_r[p*8 +: 8];
        default:       rd_val = 8'h00;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 8'h00;
      rresp_r  <= RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_val;
        rresp_r  <= decode_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // pin muxing
  always_comb begin
    logic din_rd;
    logic sel_oe;
    logic sel_out;
    sel_oe  = 1'b0;
    sel_out = 1'b0;
    din_rd = arvalid & decode_ok(araddr) & (idx_of(araddr) == IDX_DIN);
    for (int k = 0; k < NP; k++) begin
      // second function: timer channels on port F, reserved on the ALT1_RESERVED pins of ports E G H J
      if (choice_r[k]) begin
        sel_oe  = alt1_oe[k] & ~ALT1_RESERVED[k];
        sel_out = alt1_out[k];
      end else begin
        sel_oe  = alt0_oe[k];
        sel_out = alt0_out[k];
      end
      if (alt_en_r[k]) begin
        pin_oe[k]  = sel_oe;
        pin_out[k] = sel_out;
      end else begin
        pin_oe[k]  = dir_r[k];
        pin_out[k] = dout_r[k];
      end
      pin_pullup_en[k] = pullup_r[k] & ~alt_en_r[k] & ~dir_r[k];
      pin_fast_slew[k] = slew_r[k];
      pin_in_buf_en[k] = alt_en_r[k]
                         | (din_rd && port_of(araddr) == k / 8);
    end
  end

  assign periph_in = sync2_r;

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_ready;
    wr_en && ce;
  endsequence

  sequence s_rd_take;
    arvalid && arready;
  endsequence

  sequence s_wr_go;
    wr_go;
  endsequence

  property p_gpio_dir;
    ((pin_oe ^ dir_r) & ~alt_en_r) == '0;
  endproperty
  a_gpio_dir: assert property (p_gpio_dir)
    else $error("gpio pin enable differs from direction");

  property p_rst_dir;
    $rose(aresetn) |-> dir_r == '0;
  endproperty
  a_rst_dir: assert property (p_rst_dir)
    else $error("direction not cleared by reset");

  property p_rst_misc;
    $rose(aresetn) |-> (pullup_r | slew_r | alt_en_r) == '0;
  endproperty
  a_rst_misc: assert property (p_rst_misc)
    else $error("control registers not cleared by reset");

  property p_read_data;
    s_rd_take |=> rvalid && rdata[7:0] == $past(rd_val)
                  && rdata[31:8] == '0;
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data does not match register");

  property p_wr_dout;
    (s_wr_ready ##0 wr_idx == IDX_DOUT)
      |=> dout_r[wr_port*8 +: 8] == $past(w_data_r) && bvalid;
  endproperty
  a_wr_dout: assert property (p_wr_dout)
    else $error("output data not updated by write");

  property p_pullup;
    pin_pullup_en == (pullup_r & ~alt_en_r & ~pin_oe);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("pull-up active outside gpio input");

  property p_slew;
    pin_fast_slew == slew_r;
  endproperty
  a_slew: assert property (p_slew)
    else $error("slew output differs from register");

  property p_alt_sel;
    ((pin_out ^ ((choice_r & alt1_out) | (~choice_r & alt0_out)))
      & alt_en_r) == '0;
  endproperty
  a_alt_sel: assert property (p_alt_sel)
    else $error("alternate output not from chosen function");

  property p_open_drain;
    ((dir_r & ~dout_r & ~alt_en_r) & (pin_out | ~pin_oe)) == '0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin not driven low");

  property p_in_buf;
    ((alt_en_r | ~pin_in_buf_en) == {NP{1'b1}}) || arvalid;
  endproperty
  a_in_buf: assert property (p_in_buf)
    else $error("input buffer on without read");

  property p_sync;
    (ce && $past(ce)) ##0 $past(ce, 2) |-> periph_in == $past(pin_in, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("synchronizer depth wrong");

  property p_gpio_out;
    ((pin_out ^ dout_r) & dir_r & ~alt_en_r) == '0;
  endproperty
  a_gpio_out: assert property (p_gpio_out)
    else $error("gpio output differs from output data");

  property p_alt_oe;
    ((pin_oe ^ ((choice_r & alt1_oe & ~ALT1_RESERVED)
                | (~choice_r & alt0_oe))) & alt_en_r) == '0;
  endproperty
  a_alt_oe: assert property (p_alt_oe)
    else $error("alternate enable not from chosen function");

  property p_din_ro;
    (s_wr_go ##0 wr_idx == IDX_DIN) |=> bvalid && bresp == RESP_SLVERR;
  endproperty
  a_din_ro: assert property (p_din_ro)
    else $error("write to input register accepted");

endmodule

//--- gppc_pkg.sv
package gppc_pkg;

  // bus address layout: byte address = index * 4 within a port window
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned IDX_LSB  = 2;
  localparam int unsigned IDX_W    = 4;
  localparam int unsigned PORT_LSB = 6;
  localparam int unsigned PORT_W   = 3;

  // register indices inside one port window
  localparam logic [3:0] IDX_ALT_EN   = 4'h0;
  localparam logic [3:0] IDX_DIR      = 4'h2;
  localparam logic [3:0] IDX_DIN      = 4'h4;
  localparam logic [3:0] IDX_DOUT     = 4'h6;
  localparam logic [3:0] IDX_PULLUP   = 4'h8;
  localparam logic [3:0] IDX_SLEW     = 4'hA;
  localparam logic [3:0] IDX_FN_CHOICE = 4'hC;

  // reset values
  localparam logic [7:0] RST_DIR       = 8'h00;
  localparam logic [7:0] RST_PULLUP    = 8'h00;
  localparam logic [7:0] RST_SLEW      = 8'h00;
  localparam logic [7:0] RST_ALT_EN    = 8'h00;
  localparam logic [7:0] RST_FN_CHOICE = 8'h00;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pins whose second function is reserved, ports B C E F G H J
  localparam logic [55:0] ALT1_RESERVED_DEF =
    56'h7F_80_3B_00_0F_00_00;

endpackage

//--- gppc_pin_model.sv
`timescale 1ns/1ps
module gppc_pin_model (
  // clock, reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // pad controls from the port block
  input  wire logic [55:0] pin_out,
  input  wire logic [55:0] pin_oe,
  input  wire logic [55:0] pin_pullup_en,
  // outside world driving the pads
  input  wire logic [55:0] ext_val,
  input  wire logic [55:0] ext_en,
  // resolved pad level
  output logic      [55:0] pin_lvl
);
  logic [55:0] last_r;
  logic [55:0] held;

  // a floating pad shows the inverse of the last level held on it
  assign held = pin_oe | ext_en | pin_pullup_en;

  always_ff @(posedge aclk) begin
    for (int k = 0; k < 56; k++) begin
      if (!aresetn) begin
        last_r[k] <= 1'b0;
      end else if (held[k]) begin
        last_r[k] <= pin_lvl[k];
      end
    end
  end

  // own driver, then outside driver, then pull-up, else drifting
  assign pin_lvl = (pin_oe & pin_out)
                 | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en & pin_pullup_en)
                 | (~pin_oe & ~ext_en & ~pin_pullup_en & ~last_r);
endmodule

//--- tb_gpio_port_pin_control.sv
`timescale 1ns/1ps
module tb_gpio_port_pin_control import gppc_pkg::*; ;
  localparam logic [3:0] IDX_L [6] = '{IDX_ALT_EN, IDX_DIR, IDX_DOUT,
                                       IDX_PULLUP, IDX_SLEW, IDX_FN_CHOICE};
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdat_q;
  logic [1:0]  bresp, rresp, rsp_q;
  logic [55:0] pin_in, pin_out, pin_oe, pin_pu, pin_fs, pin_ib, per_in;
  logic [55:0] a0o, a0e, a1o, a1e, ext_val, ext_en;
  logic [7:0]  d, s, m;
  int          errors, checked, p, j;

  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end

  gppc_top dut_u (.aclk(aclk), .aresetn(aresetn), .ce(1'h1),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pu), .pin_fast_slew(pin_fs), .pin_in_buf_en(pin_ib),
    .alt0_out(a0o), .alt0_oe(a0e), .alt1_out(a1o), .alt1_oe(a1e),
    .periph_in(per_in));

  gppc_pin_model pins_u (.aclk(aclk), .aresetn(aresetn),
    .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pu), .ext_val(ext_val), .ext_en(ext_en),
    .pin_lvl(pin_in));

  function automatic logic [11:0] ra(int pt, logic [3:0] i);
    return 12'((pt * 16 + i) * 4);
  endfunction

  function automatic logic [7:0] mux(logic [7:0] c, x0, x1, rs);
    return (~c & x0) | (c & ~rs & x1);
  endfunction

  function automatic logic [7:0] rsv(int pt);
    return ALT1_RESERVED_DEF[pt*8 +: 8];
  endfunction

  task automatic chk(input string n, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [7:0] v);
    logic ah, wh, dn;
    @(posedge aclk);
    if (w) begin
      awaddr  <= a;
      wdata   <= {24'h0, v};
      awvalid <= 1'h1;
      wvalid  <= 1'h1;
      bready  <= 1'h1;
    end else begin
      araddr  <= a;
      arvalid <= 1'h1;
      rready  <= 1'h1;
    end
    dn = 1'h0;
    while (!dn) begin
      @(negedge aclk);
      ah = (awvalid & awready) | (arvalid & arready);
      wh = wvalid & wready;
      dn = w ? bvalid : rvalid;
      rsp_q = w ? bresp : rresp;
      rdat_q = rdata;
      @(posedge aclk);
      if (ah) begin
        awvalid <= 1'h0;
        arvalid <= 1'h0;
      end
      if (wh) wvalid <= 1'h0;
    end
    bready <= 1'h0;
    rready <= 1'h0;
  endtask

  task automatic wchk(input int pt, input logic [3:0] i,
                      input logic [7:0] v, input logic [1:0] er);
    xfer(1'h1, ra(pt, i), v);
    chk("bresp", 32'(er), 32'(rsp_q));
  endtask

  task automatic rchk(input int pt, input logic [3:0] i,
                      input logic [7:0] e, input logic [1:0] er);
    xfer(1'h0, ra(pt, i), 8'h00);
    chk("rdata", 32'(e), rdat_q);
    chk("rresp", 32'(er), 32'(rsp_q));
  endtask

  task automatic give_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    give_verdict;
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = '0;
    {ext_val, ext_en, errors, checked} = '0;
    p = $urandom(32'hE2B7);
    {a0o, a0e} = 112'({$urandom, $urandom, $urandom, $urandom});
    {a1o, a1e} = 112'({$urandom, $urandom, $urandom, $urandom});
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    for (int k = 0; k < 7; k++) begin
      foreach (IDX_L[i])
        if (IDX_L[i] != IDX_DOUT)
          rchk(k, IDX_L[i], 8'h00, RESP_OKAY);
      wchk(k, IDX_DOUT, 8'h00, RESP_OKAY);
    end
    $display("test reset values done");
    for (int n = 0; n < 40; n++) begin
      p = $urandom % 7;
      j = $urandom % 6;
      d = 8'($urandom);
      if (IDX_L[j] == IDX_FN_CHOICE) d &= ~rsv(p);
      wchk(p, IDX_L[j], d, RESP_OKAY);
      rchk(p, IDX_L[j], d, RESP_OKAY);
    end
    wchk(2, IDX_DIN, 8'h5A, RESP_SLVERR);
    rchk(2, 4'h1, 8'h00, RESP_SLVERR);
    rchk(7, IDX_DIR, 8'h00, RESP_SLVERR);
    wchk(0, 4'hE, 8'h11, RESP_SLVERR);
    for (int k = 0; k < 42; k++) wchk(k / 6, IDX_L[k % 6], 8'h00, RESP_OKAY);
    $display("test register access done");
    d = 8'($urandom);
    wchk(2, IDX_DOUT, d, RESP_OKAY);
    wchk(2, IDX_DIR, 8'hFF, RESP_OKAY);
    chk("oe", 32'hFF, 32'(pin_oe[23:16]));
    chk("out", 32'(d), 32'(pin_out[23:16]));
    repeat (4) @(posedge aclk);
    rchk(2, IDX_DIN, d, RESP_OKAY);
    chk("periph", 32'(d), 32'(per_in[23:16]));
    wchk(2, IDX_DIR, 8'h00, RESP_OKAY);
    s = 8'($urandom);
    ext_val[23:16] <= s;
    ext_en[23:16] <= 8'hFF;
    repeat (4) @(posedge aclk);
    chk("oe", 32'h00, 32'(pin_oe[23:16]));
    rchk(2, IDX_DIN, s, RESP_OKAY);
    rchk(2, IDX_DOUT, d, RESP_OKAY);
    ext_en[23:16] <= 8'h00;
    wchk(2, IDX_DOUT, 8'h00, RESP_OKAY);
    wchk(2, IDX_PULLUP, 8'hFF, RESP_OKAY);
    wchk(2, IDX_DIR, 8'h0F, RESP_OKAY);
    chk("pullup", 32'hF0, 32'(pin_pu[23:16]));
    chk("gpio inbuf", 32'h00, 32'(pin_ib[23:16]));
    repeat (4) @(posedge aclk);
    rchk(2, IDX_DIN, 8'hF0, RESP_OKAY);
    wchk(2, IDX_SLEW, s, RESP_OKAY);
    chk("slew", 32'(s), 32'(pin_fs[23:16]));
    $display("test gpio pins done");
    for (int k = 3; k < 7; k += 3) begin
      m = rsv(k);
      d = 8'($urandom) & ~m;
      wchk(k, IDX_PULLUP, 8'hFF, RESP_OKAY);
      wchk(k, IDX_SLEW, s, RESP_OKAY);
      wchk(k, IDX_FN_CHOICE, d, RESP_OKAY);
      wchk(k, IDX_ALT_EN, 8'hFF, RESP_OKAY);
      chk("alt out", 32'(mux(d, a0o[k*8+:8], a1o[k*8+:8], m)),
          32'(pin_out[k*8+:8] & ~(d & m)));
      chk("alt oe", 32'(mux(d, a0e[k*8+:8], a1e[k*8+:8], m)),
          32'(pin_oe[k*8+:8]));
      chk("alt pullup", 32'h00, 32'(pin_pu[k*8+:8]));
      chk("alt slew", 32'(s), 32'(pin_fs[k*8+:8]));
      chk("alt inbuf", 32'hFF, 32'(pin_ib[k*8+:8]));
      wchk(k, IDX_ALT_EN, 8'h00, RESP_OKAY);
      chk("gpio oe", 32'h00, 32'(pin_oe[k*8+:8]));
    end
    $display("test alternate functions done");
    wchk(2, IDX_DOUT, 8'hA5, RESP_OKAY);
    aresetn <= 1'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    rchk(2, IDX_DOUT, 8'hA5, RESP_OKAY);
    rchk(2, IDX_DIR, 8'h00, RESP_OKAY);
    rchk(2, IDX_PULLUP, 8'h00, RESP_OKAY);
    rchk(2, IDX_SLEW, 8'h00, RESP_OKAY);
    $display("test second reset done");
    give_verdict;
  end
endmodule
